// ===== aaf_alarm_flags.sv
// Alarm flag register bank read over the serial port.
// Overview of operation
// - Live flag is one while limit crossed.
// - Sticky flag latches, clears when register read.
// - Overview bit is OR of channel's sticky.
// - Overview bit position equals channel number.
// - Sticky byte pairs channel low, high from MSB.
// - Live byte uses the same pairing.
// - Flag reads one on alarm, zero otherwise.
// - All flags reset to zero, not writable.
// - Four-channel part ignores writes, reads ones for channels 4 to 7.
// - Two thresholds per channel, four flags each.
// - Flags live at addresses 11h through 14h.
`timescale 1ns/1ns
module aaf_alarm_flags #(
  parameter int NUM_CH = aaf_pkg::NUM_CH_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Threshold comparator results, one pair per channel
  input wire aaf_pkg::aaf_cond_t [7:0] cond,
  // Serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_en,
  // Any sticky flag set, for the alarm pin
  output logic alarm_any
);

  localparam int NGRP = aaf_pkg::NUM_CH_MAX / aaf_pkg::CH_PER_REG;

  // Flag state gathered from the cells.
  logic [7:0] live_lo;
  logic [7:0] live_hi;
  logic [7:0] trip_lo;
  logic [7:0] trip_hi;
  logic [7:0] overview;
  wire [NGRP-1:0][7:0] trip_byte;
  wire [NGRP-1:0][7:0] live_byte;
  logic [NGRP-1:0] clr_grp;

  // One live and one sticky flag for each of the two thresholds of every channel.
  generate
    for (genvar ch = 0; ch < aaf_pkg::NUM_CH_MAX; ch++) begin : g_ch
      localparam int G = ch / aaf_pkg::CH_PER_REG;
      localparam int K = ch % aaf_pkg::CH_PER_REG;
      localparam bit PRESENT = (ch < NUM_CH);
      aaf_flag_cell u_lo (
        .clk(clk),
        .rst(rst),
        .cond(cond[ch].lo & PRESENT),
        .clr(clr_grp[G]),
        .live(live_lo[ch]),
        .trip(trip_lo[ch])
      );
      aaf_flag_cell u_hi (
        .clk(clk),
        .rst(rst),
        .cond(cond[ch].hi & PRESENT),
        .clr(clr_grp[G]),
        .live(live_hi[ch]),
        .trip(trip_hi[ch])
      );
      // Low flag above high flag, channel 0 of the group in the top pair.
      assign trip_byte[G][7-2*K] = trip_lo[ch];
      assign trip_byte[G][6-2*K] = trip_hi[ch];
      assign live_byte[G][7-2*K] = live_lo[ch];
      assign live_byte[G][6-2*K] = live_hi[ch];
      assign overview[ch] = trip_lo[ch] | trip_hi[ch];
    end
  endgenerate

  // Serial inputs pass two flip-flops; a third copy of the clock finds its edges.
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_d;
  logic sclk_s;
  logic cs_s;
  logic sdi_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
      sclk_d <= 1'b1;
    end else begin
      sync_a <= {sclk, cs_n, sdi};
      sync_b <= sync_a;
      sclk_d <= sync_b[2];
    end
  end

  assign sclk_s = sync_b[2];
  assign cs_s = sync_b[1];
  assign sdi_s = sync_b[0];

  // Serial port state.
  aaf_pkg::aaf_state_t state;
  aaf_pkg::aaf_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic [7:0] out_sr;
  logic [7:0] next_out_sr;
  logic sdo_q;
  logic next_sdo;
  logic next_alarm;
  logic [15:0] frame;
  logic [6:0] rd_addr;
  logic [7:0] rd_byte;
  logic load;
  logic rise;
  logic fall;

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // Read value for an address; on a part of four channels or fewer, channels 4 to 7 read as ones.
  always_comb begin
    case (rd_addr)
      aaf_pkg::ADDR_OVERVIEW: begin
        rd_byte = overview;
        if (NUM_CH <= aaf_pkg::CH_PER_REG) begin
          rd_byte[7:4] = aaf_pkg::READ_ONES[7:4];
        end
      end
      aaf_pkg::ADDR_TRIP_LOW: rd_byte = trip_byte[0];
      aaf_pkg::ADDR_LIVE_LOW: rd_byte = live_byte[0];
      aaf_pkg::ADDR_TRIP_HIGH: rd_byte = (NUM_CH > aaf_pkg::CH_PER_REG) ? trip_byte[1]
                                          : aaf_pkg::READ_ONES;
      aaf_pkg::ADDR_LIVE_HIGH: rd_byte = (NUM_CH > aaf_pkg::CH_PER_REG) ? live_byte[1]
                                          : aaf_pkg::READ_ONES;
      default: rd_byte = aaf_pkg::READ_UNMAPPED;
    endcase
  end

  // Frame decode: shift in the command, then shift out the read byte; writes are dropped.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cmd = cmd;
    next_out_sr = out_sr;
    next_sdo = sdo_q;
    next_alarm = |overview;
    frame = {cmd[14:0], sdi_s};
    rd_addr = frame[aaf_pkg::ADDR_MSB:aaf_pkg::ADDR_LSB];
    load = 1'b0;
    clr_grp = '0;
    if (cs_s) begin
      next_state = aaf_pkg::ST_IDLE;
      next_cnt = 5'h00;
      next_sdo = 1'b0;
    end else begin
      case (state)
        aaf_pkg::ST_IDLE: begin
          next_state = aaf_pkg::ST_CMD;
          next_cnt = 5'h00;
        end
        aaf_pkg::ST_CMD: begin
          if (rise) begin
            next_cmd = frame;
            next_cnt = cnt + 5'h01;
            if (cnt == 5'(aaf_pkg::CMD_BITS - 1)) begin
              next_state = aaf_pkg::ST_DATA;
              next_cnt = 5'h00;
              if (!frame[aaf_pkg::WRITE_BIT]) begin
                load = 1'b1;
                next_out_sr = rd_byte;
                // Reading a sticky register clears the flags it showed.
                clr_grp[0] = (rd_addr == aaf_pkg::ADDR_TRIP_LOW);
                clr_grp[1] = (rd_addr == aaf_pkg::ADDR_TRIP_HIGH);
              end
            end
          end
        end
        aaf_pkg::ST_DATA: begin
          if (fall && cnt < 5'(aaf_pkg::DATA_BITS)) begin
            next_sdo = out_sr[7];
            next_out_sr = {out_sr[6:0], 1'b0};
            next_cnt = cnt + 5'h01;
          end
        end
        default: next_state = aaf_pkg::ST_IDLE;
      endcase
    end
  end

  // Serial port registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= aaf_pkg::ST_IDLE;
      cnt <= 5'h00;
      cmd <= 16'h0000;
      out_sr <= aaf_pkg::FLAG_RESET;
      sdo_q <= 1'b0;
      alarm_any <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      out_sr <= next_out_sr;
      sdo_q <= next_sdo;
      alarm_any <= next_alarm;
    end
  end

  assign sdo = sdo_q;
  assign sdo_en = (state == aaf_pkg::ST_DATA);

  // A live alarm on either threshold must already show in the channel's overview bit.
  chk_overview_or: assert property (@(posedge clk) disable iff (rst)
    ((live_lo | live_hi) & ~overview) == 8'h00)
    else $error("Overview bit missing for a live alarm.");
  chk_read_clears: assert property (@(posedge clk) disable iff (rst)
    load && rd_addr == aaf_pkg::ADDR_TRIP_LOW && cond[0] == 2'b00 |=> trip_byte[0][7:6] == 2'b00)
    else $error("Sticky flags of channel 0 survived a read.");
  chk_live_read: assert property (@(posedge clk) disable iff (rst)
    load && rd_addr == aaf_pkg::ADDR_LIVE_LOW |=> out_sr == $past(live_byte[0]))
    else $error("Live register read returned wrong byte.");
  chk_absent_ones: assert property (@(posedge clk) disable iff (rst)
    load && NUM_CH <= 4 && rd_addr == aaf_pkg::ADDR_TRIP_HIGH |=> out_sr == 8'hFF)
    else $error("Absent channel register did not read ones.");
  chk_sdo_quiet: assert property (@(posedge clk) disable iff (rst)
    cs_s |=> !sdo_en ##1 !sdo) else $error("Serial output active outside a frame.");

endmodule : aaf_alarm_flags

// ===== aaf_flag_cell.sv
// One threshold's live and sticky alarm flag pair.
`timescale 1ns/1ns
module aaf_flag_cell (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Condition and read clear
  input wire logic cond,
  input wire logic clr,
  // Flags
  output logic live,
  output logic trip
);

  logic next_live;
  logic next_trip;

  // Live follows the condition; sticky holds until a read, and a new event beats the clear.
  always_comb begin
    next_live = cond;
    next_trip = cond | (trip & ~clr);
  end

  // Both flags clear to zero on reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live <= 1'b0;
      trip <= 1'b0;
    end else begin
      live <= next_live;
      trip <= next_trip;
    end
  end

  chk_live_follows: assert property (@(posedge clk) disable iff (rst)
    ##1 live == $past(cond)) else $error("Live flag does not follow condition.");
  chk_trip_sets: assert property (@(posedge clk) disable iff (rst)
    cond |=> trip) else $error("Sticky flag missed an event.");
  chk_trip_holds: assert property (@(posedge clk) disable iff (rst)
    trip && !clr |=> trip) else $error("Sticky flag dropped without a read.");
  chk_trip_clears: assert property (@(posedge clk) disable iff (rst)
    trip && clr && !cond |=> !trip) else $error("Sticky flag not cleared by read.");

endmodule : aaf_flag_cell

// ===== aaf_host_model.sv
// Host model that reads the flag registers over the serial port.
`timescale 1ns/1ns
module aaf_host_model (
  // Clock
  input wire logic clk,
  // Serial port, one read line per part
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic [1:0] sdo
);
  logic [7:0] rd8;
  logic [7:0] rd4;

  // The link clock stays low outside frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Waits n edges, then steps just off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Command MSB first, then eight read bits, sampled late in the high phase for margin.
  task automatic frame(input logic [6:0] addr, input logic wr);
    logic [15:0] cmd;
    cmd = {addr, wr, 8'hFF};
    cs_n = 1'b0;
    tick(6);
    for (int i = 0; i < 24; i++) begin
      sdi = (i < 16) ? cmd[15 - i] : ~sdi;
      tick(4);
      sclk = 1'b1;
      tick(3);
      if (i >= 16) begin
        rd8 = {rd8[6:0], sdo[0]};
        rd4 = {rd4[6:0], sdo[1]};
      end
      tick(1);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    tick(6);
  endtask : frame
endmodule : aaf_host_model

// ===== aaf_pkg.sv
// Shared constants and types for the alarm flag register bank.
package aaf_pkg;

  // Register addresses on the serial port.
  localparam logic [6:0] ADDR_OVERVIEW = 7'h10;
  localparam logic [6:0] ADDR_TRIP_LOW = 7'h11;
  localparam logic [6:0] ADDR_LIVE_LOW = 7'h12;
  localparam logic [6:0] ADDR_TRIP_HIGH = 7'h13;
  localparam logic [6:0] ADDR_LIVE_HIGH = 7'h14;

  // Read values and reset values.
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] READ_ONES = 8'hFF;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Frame layout: address, write bit, data, then the read byte.
  localparam int CMD_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 9;
  localparam int WRITE_BIT = 8;

  // Channel counts.
  localparam int NUM_CH_MAX = 8;
  localparam int NUM_CH_DEF = 8;
  localparam int CH_PER_REG = 4;

  // Comparator result of one channel.
  typedef struct packed {
    logic lo;
    logic hi;
  } aaf_cond_t;

  // Serial port states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD = 3'b010,
    ST_DATA = 3'b100
  } aaf_state_t;

endpackage : aaf_pkg

// ===== adc_alarm_flag_registers_test.sv
// Self-checking bench for the alarm flag register bank.
`timescale 1ns/1ns
module adc_alarm_flag_registers_test;
  logic clk;
  logic rst;
  aaf_pkg::aaf_cond_t [7:0] cond;
  logic sclk, cs_n, sdi;
  logic [1:0] sdo;
  logic [1:0] sdo_en;
  logic [1:0] alarm_any;
  int err_count;
  int n_tests;

  // The full part and the four-channel part hear the same frames.
  aaf_alarm_flags #(.NUM_CH(8)) DUT (.clk(clk), .rst(rst), .cond(cond), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo[0]), .sdo_en(sdo_en[0]), .alarm_any(alarm_any[0]));
  aaf_alarm_flags #(.NUM_CH(4)) DUT_4CH (.clk(clk), .rst(rst), .cond(cond), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo[1]), .sdo_en(sdo_en[1]), .alarm_any(alarm_any[1]));
  aaf_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  // Clock with a 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Reads one register from both parts.
  task automatic rd(input logic [6:0] a, input logic [7:0] e8, input logic [7:0] e4);
    host.frame(a, 1'b0);
    check($sformatf("reg %h", a), e8, host.rd8);
    check($sformatf("reg %h small", a), e4, host.rd4);
  endtask : rd

  // Reset values, absent channels, an unmapped place and idle outputs.
  task automatic t_reset;
    rd(7'h10, 8'h00, 8'hF0);
    rd(7'h11, 8'h00, 8'h00);
    rd(7'h12, 8'h00, 8'h00);
    rd(7'h13, 8'h00, 8'hFF);
    rd(7'h20, 8'h00, 8'h00);
    check("idle", 8'h00, {4'h0, sdo_en, alarm_any});
    $display("test reset done");
  endtask : t_reset

  // Live and sticky flags, overview, ignored write and clear on read.
  task automatic t_flags;
    int n;
    cond[1].hi = 1'b1;
    cond[2].lo = 1'b1;
    cond[5].hi = 1'b1;
    n = 0;
    while (alarm_any[0] !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("alarm_any", 8'h01, {7'h0, alarm_any[0]});
    rd(7'h12, 8'h18, 8'h18);
    rd(7'h14, 8'h10, 8'hFF);
    cond = '0;
    rd(7'h12, 8'h00, 8'h00);
    host.frame(7'h11, 1'b1);
    rd(7'h10, 8'h26, 8'hF6);
    rd(7'h11, 8'h18, 8'h18);
    rd(7'h11, 8'h00, 8'h00);
    rd(7'h13, 8'h10, 8'hFF);
    rd(7'h10, 8'h00, 8'hF0);
    check("alarm_any", 8'h00, {6'h0, alarm_any});
    $display("test flags done");
  endtask : t_flags

  // A held condition survives the clearing read.
  task automatic t_hold;
    cond[0].lo = 1'b1;
    cond[3].hi = 1'b1;
    rd(7'h12, 8'h81, 8'h81);
    rd(7'h11, 8'h81, 8'h81);
    cond = '0;
    rd(7'h11, 8'h81, 8'h81);
    rd(7'h11, 8'h00, 8'h00);
    $display("test hold done");
  endtask : t_hold

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #3000000;
    err_count++;
    complete_run();
  end

  // Reset for 20 cycles, then the tests in order.
  initial begin
    err_count = 0;
    n_tests = 0;
    cond = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_flags();
    t_hold();
    complete_run();
  end
endmodule : adc_alarm_flag_registers_test
